// *** rtl/scc_map.svh ***
// register offsets, field positions, reset values and notes on behaviour
// Notes on behaviour
// - horizontal override set: select bit chooses source
// - horizontal select: 0 dedicated, 1 green sync
// - vertical output inverted when invert bit 0
// - vertical override set: select bit chooses source
// - vertical select: 0 pin, 1 separator
// - clamp source 0: internal clamp from leading edge
// - clamp source 1: external pin clamps channels
// - clamp polarity 1 means pin active low
// - coast select: 0 pin, 1 active vertical sync
// - coast polarity: detected, or software bit overridden
// - asserted coast makes clock ignore horizontal sync
// - seek mode allowed only when bit is 1
// - power bit 0 means full power down
// - slicer code maps inversely in 10 mV steps
// - red clamp: 0 ground, 1 midscale
// - green clamp: 0 ground, 1 midscale
// - slicer threshold resets to 23
// - reset clamp pol 1, coast pol 1, seek 1
// - auto horizontal: lone detected source wins
// - auto vertical: pin if active, else separator
`ifndef SCC_MAP_SVH
`define SCC_MAP_SVH
`define SCC_OFS_SYNC     8'h0e
`define SCC_OFS_CCP      8'h0f
`define SCC_OFS_SLICE    8'h10
`define SCC_RST_SYNC     8'h40
`define SCC_RST_CCP      8'h4e
`define SCC_RST_SLICE    8'hb8
`define SCC_CCP_MASK     8'hfe
`define SCC_B_HPOL_OVR   7
`define SCC_B_HPOL       6
`define SCC_B_HSRC_OVR   4
`define SCC_B_HSRC_SEL   3
`define SCC_B_VINV       2
`define SCC_B_VSRC_OVR   1
`define SCC_B_VSRC_SEL   0
`define SCC_B_CLMP_SRC   7
`define SCC_B_CLMP_POL   6
`define SCC_B_COAST_SEL  5
`define SCC_B_CPOL_OVR   4
`define SCC_B_CPOL       3
`define SCC_B_SEEK       2
`define SCC_B_PWR        1
`define SCC_F_SLICE_HI   7
`define SCC_F_SLICE_LO   3
`define SCC_B_RCLMP      2
`define SCC_B_GCLMP      1
`define SCC_BITS_BYTE    4'h8
`endif

// *** rtl/scc_pkg.sv ***
// types shared by the sync, clamp and coast control block
package scc_pkg;
  // serial port states, gray coded along the usual path
  typedef enum logic [3:0] {
    scc_idle = 4'h0,
    scc_addr = 4'h1,
    scc_aack = 4'h3,
    scc_ptr  = 4'h2,
    scc_pack = 4'h6,
    scc_wdat = 4'h7,
    scc_wack = 4'h5,
    scc_rdat = 4'h4,
    scc_rack = 4'hc
  } scc_state_t;
endpackage

// *** rtl/scc_control.sv ***
// sync source, clamp, coast and power control fields behind the 2-wire port
`include "scc_map.svh"
module scc_control import scc_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h4c  // arbitrary default
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       hsync_in,
  input  wire logic       green_embedded_sync_input,
  input  wire logic       vsync_in,
  input  wire logic       sep_vsync,
  input  wire logic       hsync_detect,
  input  wire logic       sog_detect,
  input  wire logic       vsync_detect,
  input  wire logic       hsync_pol_detected,
  input  wire logic       coast_pol_detected,
  input  wire logic       clamp_pin,
  input  wire logic       coast_pin,
  input  wire logic       no_sync_activity,
  input  wire logic [7:0] clamp_placement,
  input  wire logic [7:0] clamp_duration,
  output logic            active_horiz_source,
  output logic            active_vert_source,
  output logic            pll_hsync,
  output logic            vsync_out,
  output logic            clamp_active,
  output logic            pll_coast,
  output logic            seek_mode_en,
  output logic            full_power_control,
  output logic [4:0]      slicer_code,
  output logic            red_clamp_mid,
  output logic            green_clamp_mid
);

  // read decode, shared by first and following read bytes
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input logic [7:0] r0e,
                                        input logic [7:0] r0f,
                                        input logic [7:0] r10);
    logic [7:0] v;
    v = 8'h00;
    if (a == `SCC_OFS_SYNC) begin
      v = r0e;
    end else if (a == `SCC_OFS_CCP) begin
      v = r0f;
    end else if (a == `SCC_OFS_SLICE) begin
      v = r10;
    end
    return v;
  endfunction

  scc_state_t st;
  scc_state_t next_st;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic       nack;
  logic       next_nack;
  logic       scl_q;
  logic       sda_q;
  logic       next_sda_oe_n;
  logic [7:0] sync_source_control;
  logic [7:0] clamp_coast_power_control;
  logic [7:0] slicer_clamp_reference;
  logic [7:0] next_r0e;
  logic [7:0] next_r0f;
  logic [7:0] next_r10;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [7:0] rx_byte;

  // port inputs count as synchronous, so edges come from one stored copy
  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;
  assign rx_byte  = shreg;

  // serial port sequencing and register writes
  always_comb begin
    next_st      = st;
    next_bit_cnt = bit_cnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_nack    = nack;
    next_sda_oe_n = sda_oe_n;
    next_r0e     = sync_source_control;
    next_r0f     = clamp_coast_power_control;
    next_r10     = slicer_clamp_reference;
    if (stop_c) begin
      next_st       = scc_idle;
      next_sda_oe_n = 1'b1;
    end else if (start_c) begin
      // a repeated start may cut any transfer short
      next_st       = scc_addr;
      next_bit_cnt  = 4'h0;
      next_sda_oe_n = 1'b1;
    end else begin
      unique case (st)
        scc_idle: begin
          next_sda_oe_n = 1'b1;
        end
        scc_addr, scc_ptr, scc_wdat: begin
          if (scl_rise) begin
            next_shreg   = {shreg[6:0], sda_in};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == `SCC_BITS_BYTE) begin
            next_bit_cnt = 4'h0;
            if (st == scc_addr) begin
              if (rx_byte[7:1] == DEV_ADDR) begin
                next_st       = scc_aack;
                next_sda_oe_n = 1'b0;
              end else begin
                next_st = scc_idle;
              end
            end else if (st == scc_ptr) begin
              next_ptr      = rx_byte;
              next_st       = scc_pack;
              next_sda_oe_n = 1'b0;
            end else begin
              // written value stands until rewritten
              if (ptr == `SCC_OFS_SYNC) begin
                next_r0e = rx_byte;
              end else if (ptr == `SCC_OFS_CCP) begin
                next_r0f = rx_byte & `SCC_CCP_MASK;
              end else if (ptr == `SCC_OFS_SLICE) begin
                next_r10 = rx_byte;
              end
              next_ptr      = ptr + 8'h01;
              next_st       = scc_wack;
              next_sda_oe_n = 1'b0;
            end
          end
        end
        scc_aack: begin
          if (scl_fall) begin
            if (shreg[0]) begin
              // read: first data bit goes out now
              next_shreg    = rd_reg(ptr, sync_source_control,
                                     clamp_coast_power_control, slicer_clamp_reference);
              next_sda_oe_n = next_shreg[7];
              next_st       = scc_rdat;
            end else begin
              next_sda_oe_n = 1'b1;
              next_st       = scc_ptr;
            end
          end
        end
        scc_pack, scc_wack: begin
          if (scl_fall) begin
            next_sda_oe_n = 1'b1;
            next_st       = scc_wdat;
          end
        end
        scc_rdat: begin
          if (scl_rise) begin
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == `SCC_BITS_BYTE) begin
              next_bit_cnt  = 4'h0;
              next_sda_oe_n = 1'b1;
              next_ptr      = ptr + 8'h01;
              next_st       = scc_rack;
            end else begin
              next_shreg    = {shreg[6:0], 1'b0};
              next_sda_oe_n = shreg[6];
            end
          end
        end
        scc_rack: begin
          if (scl_rise) begin
            next_nack = sda_in;
          end else if (scl_fall) begin
            if (nack) begin
              // master is done; wait for stop or start
              next_st = scc_idle;
            end else begin
              next_shreg    = rd_reg(ptr, sync_source_control,
                                     clamp_coast_power_control, slicer_clamp_reference);
              next_sda_oe_n = next_shreg[7];
              next_st       = scc_rdat;
            end
          end
        end
        default: begin
          next_st = scc_idle;
        end
      endcase
    end
  end

  // serial port and register storage
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st                        <= scc_idle;
      bit_cnt                   <= 4'h0;
      shreg                     <= 8'h00;
      ptr                       <= 8'h00;
      nack                      <= 1'b0;
      scl_q                     <= 1'b1;
      sda_q                     <= 1'b1;
      sda_out                   <= 1'b0;
      sda_oe_n                  <= 1'b1;
      sync_source_control       <= `SCC_RST_SYNC;
      clamp_coast_power_control <= `SCC_RST_CCP;
      slicer_clamp_reference    <= `SCC_RST_SLICE;
    end else begin
      st                        <= next_st;
      bit_cnt                   <= next_bit_cnt;
      shreg                     <= next_shreg;
      ptr                       <= next_ptr;
      nack                      <= next_nack;
      scl_q                     <= scl_in;
      sda_q                     <= sda_in;
      sda_out                   <= 1'b0;
      sda_oe_n                  <= next_sda_oe_n;
      sync_source_control       <= next_r0e;
      clamp_coast_power_control <= next_r0f;
      slicer_clamp_reference    <= next_r10;
    end
  end

  // sync selection, clamp and coast datapath
  logic       ahs_c;
  logic       avs_c;
  logic       hs_sel_c;
  logic       vs_sel_c;
  logic       hs_pol_c;
  logic       hs_lead_c;
  logic       cpol_c;
  logic       coast_src_c;
  logic       hs_q;
  logic [8:0] clk_cnt;
  logic [8:0] next_clk_cnt;
  logic [8:0] win_end_c;
  logic       next_clamp;

  always_comb begin
    if (sync_source_control[`SCC_B_HSRC_OVR]) begin
      ahs_c = sync_source_control[`SCC_B_HSRC_SEL];
    end else if (sog_detect && !hsync_detect) begin
      ahs_c = 1'b1;
    end else if (hsync_detect && !sog_detect) begin
      ahs_c = 1'b0;
    end else begin
      ahs_c = sync_source_control[`SCC_B_HSRC_SEL];
    end
    if (sync_source_control[`SCC_B_VSRC_OVR]) begin
      avs_c = sync_source_control[`SCC_B_VSRC_SEL];
    end else begin
      avs_c = ~vsync_detect;
    end
    hs_sel_c = ahs_c ? green_embedded_sync_input : hsync_in;
    vs_sel_c = avs_c ? sep_vsync : vsync_in;
    hs_pol_c = sync_source_control[`SCC_B_HPOL_OVR] ?
               sync_source_control[`SCC_B_HPOL] : hsync_pol_detected;
    hs_lead_c = (hs_sel_c == hs_pol_c) && (hs_q != hs_pol_c);
    cpol_c = clamp_coast_power_control[`SCC_B_CPOL_OVR] ?
             clamp_coast_power_control[`SCC_B_CPOL] : coast_pol_detected;
    coast_src_c = clamp_coast_power_control[`SCC_B_COAST_SEL] ?
                  vs_sel_c : coast_pin;
    // counter saturates so a lost edge cannot re-trigger the window
    if (hs_lead_c) begin
      next_clk_cnt = 9'h000;
    end else if (clk_cnt != 9'h1ff) begin
      next_clk_cnt = clk_cnt + 9'h001;
    end else begin
      next_clk_cnt = clk_cnt;
    end
    win_end_c = {1'b0, clamp_placement} + {1'b0, clamp_duration};
    if (clamp_coast_power_control[`SCC_B_CLMP_SRC]) begin
      next_clamp = clamp_coast_power_control[`SCC_B_CLMP_POL] ?
                   ~clamp_pin : clamp_pin;
    end else begin
      next_clamp = (clk_cnt >= {1'b0, clamp_placement}) &&
                   (clk_cnt < win_end_c);
    end
  end

  // all outputs registered; field changes show one cycle after the write
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      hs_q                <= 1'b0;
      clk_cnt             <= 9'h1ff;
      active_horiz_source <= 1'b0;
      active_vert_source  <= 1'b0;
      pll_hsync           <= 1'b0;
      vsync_out           <= 1'b0;
      clamp_active        <= 1'b0;
      pll_coast           <= 1'b0;
      seek_mode_en        <= 1'b0;
      full_power_control  <= 1'b1;
      slicer_code         <= 5'h17;
      red_clamp_mid       <= 1'b0;
      green_clamp_mid     <= 1'b0;
    end else begin
      hs_q                <= hs_sel_c;
      clk_cnt             <= next_clk_cnt;
      active_horiz_source <= ahs_c;
      active_vert_source  <= avs_c;
      pll_hsync           <= hs_sel_c;
      vsync_out           <= vs_sel_c ^ ~sync_source_control[`SCC_B_VINV];
      clamp_active        <= next_clamp;
      pll_coast           <= (coast_src_c == cpol_c);
      seek_mode_en        <= clamp_coast_power_control[`SCC_B_SEEK] &
                             no_sync_activity;
      full_power_control  <= clamp_coast_power_control[`SCC_B_PWR];
      slicer_code         <= slicer_clamp_reference[`SCC_F_SLICE_HI:`SCC_F_SLICE_LO];
      red_clamp_mid       <= slicer_clamp_reference[`SCC_B_RCLMP];
      green_clamp_mid     <= slicer_clamp_reference[`SCC_B_GCLMP];
    end
  end

endmodule

// *** tb/scc_control_asserts.sv ***
// concurrent checks on the ports of the sync, clamp and coast control block
module scc_control_asserts (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_n,
  input wire logic       hsync_in,
  input wire logic       green_embedded_sync_input,
  input wire logic       no_sync_activity,
  input wire logic       active_horiz_source,
  input wire logic       pll_hsync,
  input wire logic       seek_mode_en,
  input wire logic       full_power_control,
  input wire logic [4:0] slicer_code,
  input wire logic       red_clamp_mid,
  input wire logic       green_clamp_mid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // the data line may only move one clock after a sampled clock fall
  ack_time_a: assert property ($changed(sda_oe_n)
    |-> !$past(scl_in) && $past(scl_in, 2))
    else $error("data line drive moved off the clock fall");
  sda_low_a: assert property (!sda_oe_n |-> sda_out == 1'b0)
    else $error("driven data line not low");
  seek_gate_a: assert property (seek_mode_en |-> $past(no_sync_activity))
    else $error("seek mode with sync activity present");
  // a source that held for two samples leaves no doubt which line fed the pll;
  // the first sample after reset still shows the reset level, so it is skipped
  hs_pin_a: assert property ($past(resetn) && !active_horiz_source
    && !$past(active_horiz_source) |-> pll_hsync == $past(hsync_in))
    else $error("pll sync not from dedicated input");
  hs_green_a: assert property ($past(resetn) && active_horiz_source
    && $past(active_horiz_source) |-> pll_hsync == $past(green_embedded_sync_input))
    else $error("pll sync not from green input");
  slice_rst_a: assert property (!$past(resetn) |-> slicer_code == 5'h17)
    else $error("slicer code not at its reset value");
  mode_rst_a: assert property (!$past(resetn) |-> full_power_control
    && !red_clamp_mid && !green_clamp_mid)
    else $error("mode outputs not at reset values");
  // no register write can land while the serial clock sits high
  field_hold_a: assert property (scl_in [*3] |-> $stable(slicer_code)
    && $stable(full_power_control) && $stable(red_clamp_mid))
    else $error("field changed without a write");
  cover property (!sda_oe_n);
  cover property (seek_mode_en);
  cover property (active_horiz_source && pll_hsync);
endmodule

// *** tb/scc_host_model.sv ***
// two-wire host that reads and writes the control registers
module scc_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h4c  // arbitrary, same as the bench instance
) (
  input  wire logic ref_clk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  // half bit of four clocks; lines move just after an edge
  task automatic hp;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask
  task automatic bitx(input logic b, output logic r);
    sda_o = b;
    hp();
    scl = 1'b1;
    hp();
    r = sda_wire;
    scl = 1'b0;
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
      q[i] = r;
    end
    bitx(last, r);
    ack = !r;
  endtask
  task automatic start;
    sda_o = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop;
    sda_o = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask
  task automatic wr(input logic [7:0] ofs, d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(ofs, 1'b1, q, a1);
    xfer(d, 1'b1, q, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // read ends with a nack so the device lets go of the line
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, n;
    start();
    xfer({DEV_ADDR, 1'b0}, 1'b1, q, a0);
    xfer(ofs, 1'b1, q, a1);
    start();
    xfer({DEV_ADDR, 1'b1}, 1'b1, q, a2);
    xfer(8'hff, 1'b1, d, n);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// *** tb/scc_control_tb.sv ***
// self-checking bench for the sync, clamp and coast control block
module scc_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk = 1'b0;
  logic       resetn, scl, sda_h, sda_w, sda_out, sda_oe_n;
  logic       hsync_in, green_embedded_sync_input, vsync_in, sep_vsync;
  logic       hsync_detect, sog_detect, vsync_detect, hsync_pol_detected;
  logic       coast_pol_detected, clamp_pin, coast_pin, no_sync_activity;
  logic [7:0] clamp_placement, clamp_duration;
  logic       active_horiz_source, active_vert_source, pll_hsync, vsync_out;
  logic       clamp_active, pll_coast, seek_mode_en, full_power_control;
  logic [4:0] slicer_code;
  logic       red_clamp_mid, green_clamp_mid, e;
  int         err_count, n_tests, cnt;
  always #12.5 ref_clk = ~ref_clk;
  // open-drain data line with pull-up
  assign sda_w = sda_h & (sda_oe_n | sda_out);
  scc_host_model host (.ref_clk, .sda_wire(sda_w), .scl, .sda_o(sda_h));
  scc_control dut (.ref_clk, .resetn, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe_n,
    .hsync_in, .green_embedded_sync_input, .vsync_in, .sep_vsync, .hsync_detect,
    .sog_detect, .vsync_detect, .hsync_pol_detected, .coast_pol_detected, .clamp_pin,
    .coast_pin, .no_sync_activity, .clamp_placement, .clamp_duration, .active_horiz_source,
    .active_vert_source, .pll_hsync, .vsync_out, .clamp_active, .pll_coast, .seek_mode_en,
    .full_power_control, .slicer_code, .red_clamp_mid, .green_clamp_mid);
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask
  // outputs trail a register write by one clock; two gives margin
  task automatic wr(input logic [7:0] o, d);
    logic ok;
    host.wr(o, d, ok);
    chk(ok, 8'h01, "write ack");
    tick(2);
  endtask
  task automatic rdchk(input logic [7:0] o, x);
    logic [7:0] d;
    logic       ok;
    host.rd(o, d, ok);
    chk(ok, 8'h01, "read ack");
    chk(d, x, "readback");
  endtask
  task automatic t_regs;
    rdchk(8'h0f, 8'h4e);
    rdchk(8'h10, 8'hb8);
    chk(full_power_control, 8'h01, "power reset");
    wr(8'h0f, 8'h4d);
    chk(full_power_control, 8'h00, "power down");
    rdchk(8'h0f, 8'h4c);
    wr(8'h0f, 8'h4e);
    wr(8'h10, 8'hfe);
    chk(slicer_code, 8'h1f, "slicer max code");
    chk({red_clamp_mid, green_clamp_mid}, 8'h03, "clamp refs mid");
    wr(8'h10, 8'h04);
    chk({slicer_code, red_clamp_mid, green_clamp_mid}, 8'h02, "slicer zero");
    wr(8'h10, 8'hb8);
    wr(8'h11, 8'h55);
    rdchk(8'h11, 8'h00);
    $display("register test done");
  endtask
  task automatic t_sync;
    for (int k = 0; k < 16; k++) begin
      {hsync_detect, sog_detect} = k[1:0];
      wr(8'h0e, {3'b010, k[3], k[2], 3'b100});
      e = k[3] ? k[2] : ((k[1] ^ k[0]) ? k[0] : k[2]);
      chk(active_horiz_source, e, "horiz source");
      chk(pll_hsync, !e, "pll sync level");
    end
    for (int k = 0; k < 16; k++) begin
      vsync_detect = k[1];
      wr(8'h0e, {5'b01000, k[0], k[3], k[2]});
      e = k[3] ? k[2] : !k[1];
      chk(active_vert_source, e, "vert source");
      chk(vsync_out, e ^ k[0], "vsync out level");
    end
    $display("sync source test done");
  endtask
  task automatic t_coast;
    wr(8'h0e, 8'h42);
    for (int k = 0; k < 8; k++) begin
      coast_pin = k[0];
      vsync_in = !k[0];
      wr(8'h0f, {2'b01, k[2], 1'b1, k[1], 3'b110});
      chk(pll_coast, (k[2] ? !k[0] : k[0]) == k[1], "coast level");
    end
    wr(8'h0f, 8'h46);
    coast_pin = 1'b1;
    for (int k = 0; k < 2; k++) begin
      coast_pol_detected = k[0];
      tick(2);
      chk(pll_coast, k[0], "detected coast pol");
    end
    $display("coast test done");
  endtask
  task automatic t_clamp;
    for (int k = 0; k < 4; k++) begin
      clamp_pin = k[0];
      wr(8'h0f, {1'b1, k[1], 6'b001110});
      chk(clamp_active, k[0] ^ k[1], "external clamp");
    end
    wr(8'h0f, 8'h4e);
    wr(8'h0e, 8'hc0);
    hsync_in = 1'b0;
    tick(4);
    hsync_in = 1'b1;
    cnt = 0;
    for (int i = 0; i < 30; i++) begin
      tick(1);
      cnt += clamp_active;
    end
    chk(cnt[7:0], clamp_duration, "internal clamp width");
    for (int s = 0; s < 2; s++) begin
      wr(8'h0f, {5'b01001, s[0], 2'b10});
      chk(seek_mode_en, s[0], "seek allowed");
      no_sync_activity = 1'b0;
      tick(2);
      chk(seek_mode_en, 8'h00, "seek with activity");
      no_sync_activity = 1'b1;
    end
    $display("clamp and seek test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    {resetn, green_embedded_sync_input, sep_vsync, hsync_detect, sog_detect} = '0;
    {vsync_detect, coast_pol_detected, clamp_pin, coast_pin} = '0;
    {hsync_in, vsync_in, hsync_pol_detected, no_sync_activity} = 4'hf;
    clamp_placement = 8'h02;
    clamp_duration = 8'h03;
    tick(3);
    resetn = 1'b1;
    tick(2);
    t_regs();
    t_sync();
    t_coast();
    t_clamp();
    close_out();
  end
  // the whole run needs roughly fifteen thousand clocks
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    $display("FAIL %0t watchdog expired", $time);
    close_out();
  end
endmodule
bind scc_control scc_control_asserts chk_u (.ref_clk, .resetn, .scl_in, .sda_out, .sda_oe_n,
  .hsync_in, .green_embedded_sync_input, .no_sync_activity, .active_horiz_source, .pll_hsync,
  .seek_mode_en, .full_power_control, .slicer_code, .red_clamp_mid, .green_clamp_mid);
